// >>> hdl/pfcd_pkg.sv
`default_nettype none
package pfcd_pkg;
  // Address width of the largest part in the family.
  localparam int ADDR_W = 19;
  // Data bus width.
  localparam int DATA_W = 8;
  // Guard addresses.
  localparam logic [14:0] ADDR_GUARD_A = 15'h5555;
  localparam logic [14:0] ADDR_GUARD_B = 15'h2aaa;
  // Command bytes.
  localparam logic [7:0] CMD_UNLOCK_A = 8'haa;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  // Lowest address bit of the sector field.
  localparam int SECTOR_LSB = 12;
  // Bus timing in nanoseconds and clock period.
  localparam int CLK_NS = 10;
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 40;
  localparam int HOLD_NS = 30;
  localparam int READ_NS = 70;
  // Cycle counts, least times rounded up.
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] READ_CYC = 4'((READ_NS + CLK_NS - 1) / CLK_NS);
  // Operation codes on the user port.
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
  localparam logic [2:0] OP_ID_ENTRY = 3'h4;
  localparam logic [2:0] OP_ID_EXIT = 3'h5;
  localparam logic [2:0] OP_ID_EXIT_LONG = 3'h6;
  localparam logic [2:0] OP_POLL = 3'h7;
  // Bus cycle phases, one-hot.
  typedef enum logic [4:0] {
    PFCD_IDLE = 5'h01,
    PFCD_SETUP = 5'h02,
    PFCD_STROBE = 5'h04,
    PFCD_HOLD = 5'h08,
    PFCD_DONE = 5'h10
  } pfcd_phase_type;
endpackage
`default_nettype wire

// >>> hdl/pfcd_bus_cycle.sv
`default_nettype none
// Runs one asynchronous bus cycle, a write or a read, on the flash pins.
module pfcd_bus_cycle (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_write,
  input wire logic [pfcd_pkg::ADDR_W-1:0] addr,
  input wire logic [pfcd_pkg::DATA_W-1:0] wdata,
  input wire logic [pfcd_pkg::DATA_W-1:0] data_bus_in,
  output logic busy,
  output logic done,
  output logic [pfcd_pkg::DATA_W-1:0] rdata,
  output logic [pfcd_pkg::ADDR_W-1:0] flash_addr,
  output logic [pfcd_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_n,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n
);
  // Current phase and its cycle counter.
  pfcd_pkg::pfcd_phase_type phase;
  logic [3:0] count;
  // Whether this cycle writes.
  logic write_cyc;
  // Three-stage input sampling of the data pins.
  logic [pfcd_pkg::DATA_W-1:0] samp1;
  logic [pfcd_pkg::DATA_W-1:0] samp2;
  logic [pfcd_pkg::DATA_W-1:0] samp3;
  // Length of the phase in progress.
  wire logic [3:0] phase_len;
  // Phase ends when the counter reaches one less than its length.
  wire logic phase_end;
  assign phase_len = (phase == pfcd_pkg::PFCD_SETUP) ? pfcd_pkg::SETUP_CYC :
                     (phase == pfcd_pkg::PFCD_STROBE) ?
                     (write_cyc ? pfcd_pkg::STROBE_CYC : pfcd_pkg::READ_CYC) :
                     pfcd_pkg::HOLD_CYC;
  assign phase_end = (count + 4'h1) >= phase_len;
  assign busy = (phase != pfcd_pkg::PFCD_IDLE);

  // Sequences the phases of one bus cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase <= pfcd_pkg::PFCD_IDLE;
      count <= 4'h0;
      write_cyc <= 1'b0;
    end else begin
      case (phase)
        // Waiting for a request.
        pfcd_pkg::PFCD_IDLE: begin
          count <= 4'h0;
          if (start) begin
            phase <= pfcd_pkg::PFCD_SETUP;
            write_cyc <= is_write;
          end
        end
        // Address and select settle before the strobe.
        pfcd_pkg::PFCD_SETUP: begin
          count <= phase_end ? 4'h0 : count + 4'h1;
          if (phase_end) begin
            phase <= pfcd_pkg::PFCD_STROBE;
          end
        end
        // Strobe or gate held low.
        pfcd_pkg::PFCD_STROBE: begin
          count <= phase_end ? 4'h0 : count + 4'h1;
          if (phase_end) begin
            phase <= pfcd_pkg::PFCD_HOLD;
          end
        end
        // Data held after the strobe rises.
        pfcd_pkg::PFCD_HOLD: begin
          count <= phase_end ? 4'h0 : count + 4'h1;
          if (phase_end) begin
            phase <= pfcd_pkg::PFCD_DONE;
          end
        end
        // One-cycle completion.
        pfcd_pkg::PFCD_DONE: begin
          phase <= pfcd_pkg::PFCD_IDLE;
        end
        default: begin
          phase <= pfcd_pkg::PFCD_IDLE;
        end
      endcase
    end
  end

  // Drives the pins from the phase; address is stable for the whole cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flash_addr <= '0;
      data_bus_out <= '0;
      data_bus_oe_n <= 1'b1;
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      if (phase == pfcd_pkg::PFCD_IDLE && start) begin
        flash_addr <= addr;
        data_bus_out <= wdata;
      end
      chip_select_n <= !(busy || start) || (phase == pfcd_pkg::PFCD_DONE);
      write_strobe_n <= !(write_cyc && phase == pfcd_pkg::PFCD_SETUP && phase_end) &&
                        !(write_cyc && phase == pfcd_pkg::PFCD_STROBE && !phase_end);
      output_gate_n <= !(!write_cyc && phase == pfcd_pkg::PFCD_SETUP && phase_end) &&
                       !(!write_cyc && phase == pfcd_pkg::PFCD_STROBE && !phase_end);
      data_bus_oe_n <= !((phase == pfcd_pkg::PFCD_IDLE && start && is_write) ||
                         (write_cyc && busy && phase != pfcd_pkg::PFCD_DONE &&
                          !(phase == pfcd_pkg::PFCD_HOLD && phase_end)));
    end
  end

  // Samples the data pins and captures read data at the end of the gate.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      samp1 <= '0;
      samp2 <= '0;
      samp3 <= '0;
      rdata <= '0;
    end else begin
      samp1 <= data_bus_in;
      samp2 <= samp1;
      samp3 <= samp2;
      if (!write_cyc && phase == pfcd_pkg::PFCD_HOLD && count == 4'h0) begin
        rdata <= samp3;
      end
    end
  end

  assign done = (phase == pfcd_pkg::PFCD_DONE);

  // Write strobe only falls while select is low.
  strobe_in_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    !write_strobe_n |-> !chip_select_n) else $error("strobe outside select");
  // Gate and strobe never low together.
  gate_strobe_excl_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(!write_strobe_n && !output_gate_n)) else $error("gate and strobe both low");
  // Host drives the bus only in write cycles.
  bus_drive_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    !data_bus_oe_n |-> !output_gate_n == 1'b0) else $error("host drives during read");
endmodule
`default_nettype wire

// >>> hdl/pfcd_host.sv
`default_nettype none
// Host controller issuing guarded command sequences to a parallel flash.
module pfcd_host #(
  parameter int POLL_LIMIT = 65535
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [pfcd_pkg::ADDR_W-1:0] req_addr,
  input wire logic [pfcd_pkg::DATA_W-1:0] req_data,
  output logic req_ready,
  output logic resp_valid,
  output logic [pfcd_pkg::DATA_W-1:0] resp_data,
  output logic resp_timeout,
  input wire logic [pfcd_pkg::DATA_W-1:0] data_bus_in,
  output logic [pfcd_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_n,
  output logic [pfcd_pkg::ADDR_W-1:0] flash_addr,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n
);
  // Operation in progress, its address and data.
  logic [2:0] op;
  logic [pfcd_pkg::ADDR_W-1:0] op_addr;
  logic [pfcd_pkg::DATA_W-1:0] op_data;
  // Index of the bus cycle within the sequence.
  logic [2:0] step;
  // Sequence active, bus cycle issued and waiting.
  logic active;
  logic issued;
  // Previous toggle-bit sample while polling.
  logic [pfcd_pkg::DATA_W-1:0] last_read;
  logic have_last;
  // Poll attempt counter.
  logic [15:0] polls;
  // Bus cycle engine signals.
  wire logic cyc_busy;
  wire logic cyc_done;
  wire logic [pfcd_pkg::DATA_W-1:0] cyc_rdata;
  // Number of writes in the sequence of the current operation.
  wire logic [2:0] nwrites;
  // Selected address and data of the current write step.
  wire logic [pfcd_pkg::ADDR_W-1:0] step_addr;
  wire logic [pfcd_pkg::DATA_W-1:0] step_data;
  // The current step is a read rather than a write.
  wire logic step_read;
  // Operation needs completion polling after its writes.
  wire logic needs_poll;
  // The guard prefix: unlock A then unlock B.
  wire logic [pfcd_pkg::ADDR_W-1:0] guard_a;
  wire logic [pfcd_pkg::ADDR_W-1:0] guard_b;
  // Bit 6 stopped toggling between two reads.
  wire logic settled;

  // Upper bits are driven low so they stand at valid levels.
  // upper bits
  assign guard_a = {{(pfcd_pkg::ADDR_W-15){1'b0}}, pfcd_pkg::ADDR_GUARD_A};
  assign guard_b = {{(pfcd_pkg::ADDR_W-15){1'b0}}, pfcd_pkg::ADDR_GUARD_B};

  assign nwrites = (op == pfcd_pkg::OP_PROGRAM) ? 3'h4 :
                   (op == pfcd_pkg::OP_SECTOR_ERASE || op == pfcd_pkg::OP_CHIP_ERASE) ? 3'h6 :
                   (op == pfcd_pkg::OP_ID_ENTRY || op == pfcd_pkg::OP_ID_EXIT_LONG) ? 3'h3 :
                   (op == pfcd_pkg::OP_ID_EXIT) ? 3'h1 : 3'h0;
  assign needs_poll = (op == pfcd_pkg::OP_PROGRAM) || (op == pfcd_pkg::OP_SECTOR_ERASE) ||
                      (op == pfcd_pkg::OP_CHIP_ERASE) || (op == pfcd_pkg::OP_POLL);
  assign step_read = (step >= nwrites);

  // Address of each write step.
  // Status reads are decoded first, so that a program poll reads its own byte.
  assign step_addr = (op == pfcd_pkg::OP_ID_EXIT || step_read) ? op_addr :
                     (step == 3'h1 || step == 3'h4) ? guard_b :
                     (step == 3'h5 && op == pfcd_pkg::OP_SECTOR_ERASE) ? op_addr :
                     (step == 3'h3 && op == pfcd_pkg::OP_PROGRAM) ? op_addr :
                     guard_a;
  // Data of each write step.
  assign step_data = (op == pfcd_pkg::OP_ID_EXIT) ? pfcd_pkg::CMD_ID_EXIT :
                     (step == 3'h0 || step == 3'h3 && nwrites == 3'h6) ? pfcd_pkg::CMD_UNLOCK_A :
                     (step == 3'h1 || step == 3'h4) ? pfcd_pkg::CMD_UNLOCK_B :
                     (step == 3'h3) ? op_data :
                     (step == 3'h5 && op == pfcd_pkg::OP_SECTOR_ERASE) ?
                     pfcd_pkg::CMD_SECTOR_ERASE :
                     (step == 3'h5) ? pfcd_pkg::CMD_CHIP_ERASE :
                     (op == pfcd_pkg::OP_PROGRAM) ? pfcd_pkg::CMD_PROGRAM :
                     (op == pfcd_pkg::OP_ID_ENTRY) ? pfcd_pkg::CMD_ID_ENTRY :
                     (op == pfcd_pkg::OP_ID_EXIT_LONG) ? pfcd_pkg::CMD_ID_EXIT :
                     pfcd_pkg::CMD_ERASE_SETUP;

  assign settled = have_last && (last_read[6] == cyc_rdata[6]);
  assign req_ready = !active;

  // Walks the command sequence and then polls until the device is ready or POLL_LIMIT polls have failed.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
      issued <= 1'b0;
      op <= pfcd_pkg::OP_READ;
      op_addr <= '0;
      op_data <= '0;
      step <= 3'h0;
      have_last <= 1'b0;
      last_read <= '0;
      polls <= 16'h0;
      resp_valid <= 1'b0;
      resp_data <= '0;
      resp_timeout <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      if (!active) begin
        // Accepts a new request; steps always start at step zero, the first guard write for guarded operations.
        // full preamble except for reads, polls and the single exit write
        if (req_valid) begin
          active <= 1'b1;
          op <= req_op;
          op_addr <= req_addr;
          op_data <= req_data;
          step <= 3'h0;
          have_last <= 1'b0;
          polls <= 16'h0;
          resp_timeout <= 1'b0;
        end
      end else if (!issued) begin
        issued <= 1'b1;
      end else if (cyc_done) begin
        issued <= 1'b0;
        if (!step_read) begin
          step <= step + 3'h1;
          // Write-only operations end after their last write.
          if (step + 3'h1 == nwrites && !needs_poll) begin
            active <= 1'b0;
            resp_valid <= 1'b1;
          end
        end else if (!needs_poll || settled || polls == 16'(POLL_LIMIT)) begin
          active <= 1'b0;
          resp_valid <= 1'b1;
          resp_data <= cyc_rdata;
          resp_timeout <= needs_poll && !settled;
        end else begin
          have_last <= 1'b1;
          last_read <= cyc_rdata;
          polls <= polls + 16'h1;
        end
      end
    end
  end

  // Bus cycle engine shared by all steps.
  pfcd_bus_cycle u_cycle (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(active && !issued),
    .is_write(!step_read),
    .addr(step_addr),
    .wdata(step_data),
    .data_bus_in(data_bus_in),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .data_bus_out(data_bus_out),
    .data_bus_oe_n(data_bus_oe_n),
    .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n)
  );

  // Program step four goes to the target address.
  prog_target_a: assert property (@(posedge ref_clk) disable iff (rst)
    active && op == pfcd_pkg::OP_PROGRAM && step == 3'h3 && !write_strobe_n |->
    flash_addr == op_addr) else $error("program address wrong");
  // Guard first write is AA at the guard address.
  guard_first_a: assert property (@(posedge ref_clk) disable iff (rst)
    active && step == 3'h0 && op != pfcd_pkg::OP_ID_EXIT && nwrites != 3'h0 &&
    !write_strobe_n |-> data_bus_out == pfcd_pkg::CMD_UNLOCK_A) else $error("guard byte");
  // Ready only while no sequence runs.
  ready_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    req_ready |-> !cyc_busy) else $error("ready while busy");
  // A response comes in the same cycle as the sequence ends.
  resp_ends_a: assert property (@(posedge ref_clk) disable iff (rst)
    resp_valid |-> req_ready) else $error("response while active");
  // Upper address bits stay low in the second guard step.
  upper_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    active && step == 3'h1 && !write_strobe_n |-> flash_addr == guard_b) else
    $error("guard address wrong");

  // A write cycle opens with select and the bus drive falling together.
  sequence write_open_s;
    $fell(chip_select_n) && !data_bus_oe_n;
  endsequence
  // The strobe then stays low for four clocks and rises again.
  sequence strobe_pulse_s;
    $fell(write_strobe_n) ##1 !write_strobe_n [*3] ##1 write_strobe_n;
  endsequence
  // A read cycle opens with select falling while the bus is left to the device.
  sequence read_open_s;
    $fell(chip_select_n) && data_bus_oe_n;
  endsequence
  // The gate then stays low for seven clocks and rises again.
  sequence gate_pulse_s;
    $fell(output_gate_n) ##1 !output_gate_n [*6] ##1 output_gate_n;
  endsequence
  // Each write gives the strobe its setup time and its full width.
  write_shape_a: assert property (@(posedge ref_clk) disable iff (rst)
    write_open_s |-> ##3 strobe_pulse_s) else $error("write strobe shape wrong");
  // Each read gives the gate its setup time and the full access time.
  read_shape_a: assert property (@(posedge ref_clk) disable iff (rst)
    read_open_s |-> ##3 gate_pulse_s) else $error("read gate shape wrong");
  // Status reads after a sequence look at the operation's own address.
  poll_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    active && step_read && !output_gate_n |-> flash_addr == op_addr) else
    $error("status read address wrong");
  // The sixth write of a sector erase carries the sector and its command.
  sector_last_a: assert property (@(posedge ref_clk) disable iff (rst)
    active && op == pfcd_pkg::OP_SECTOR_ERASE && step == 3'h5 && !write_strobe_n |->
    flash_addr == op_addr && data_bus_out == pfcd_pkg::CMD_SECTOR_ERASE) else
    $error("sector erase write wrong");
  // The sixth write of a chip erase goes to the first guard address.
  chip_last_a: assert property (@(posedge ref_clk) disable iff (rst)
    active && op == pfcd_pkg::OP_CHIP_ERASE && step == 3'h5 && !write_strobe_n |->
    flash_addr == guard_a && data_bus_out == pfcd_pkg::CMD_CHIP_ERASE) else
    $error("chip erase write wrong");
  // The third write of identification entry carries the entry command.
  id_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
    active && op == pfcd_pkg::OP_ID_ENTRY && step == 3'h2 && !write_strobe_n |->
    flash_addr == guard_a && data_bus_out == pfcd_pkg::CMD_ID_ENTRY) else
    $error("entry write wrong");
  // The single exit write carries the exit command.
  id_exit_a: assert property (@(posedge ref_clk) disable iff (rst)
    active && op == pfcd_pkg::OP_ID_EXIT && !write_strobe_n |->
    data_bus_out == pfcd_pkg::CMD_ID_EXIT) else
    $error("exit write wrong");
endmodule
`default_nettype wire

// >>> sim/pfcd_flash_model.sv
`default_nettype none
// Behavioural flash device: guarded command decoder, byte array, busy status and ID mode.
module pfcd_flash_model #(
  parameter int BUSY_NS = 2000,
  parameter int ACCESS_NS = 30,
  parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary identity value.
  parameter logic [7:0] DEVICE_CODE = 8'h5d // Arbitrary identity value.
) (
  input wire logic [18:0] flash_addr,
  input wire logic [7:0] data_in,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  output logic [7:0] dq_out,
  output logic dq_en,
  output logic [7:0] abort_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // Byte array of the whole part; erased bytes read as all ones.
  logic [7:0] mem [0:524287];
  logic [18:0] lat_addr, op_addr;
  logic [7:0] lat_data, op_val, rd_val;
  logic [14:0] cmd_addr;
  logic busy, id_mode, toggle, armed;
  int step, op_kind;
  event start_ev;
  wire wr_n = chip_select_n | write_strobe_n | ~output_gate_n;
  wire rd_n = chip_select_n | output_gate_n;
  initial begin
    step = 0; busy = 0; id_mode = 0; toggle = 0; armed = 0;
    dq_en = 0; dq_out = 8'h00; abort_count = 8'h00;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // A broken sequence drops straight back to read mode.
  task automatic fail();
    step = 0;
    abort_count = abort_count + 8'h01;
  endtask
  // Starts the timed internal operation.
  task automatic launch(input int kind);
    step = 0; op_kind = kind; op_addr = lat_addr; op_val = lat_data; busy = 1;
    -> start_ev;
  endtask
  always @(negedge wr_n) begin
    lat_addr = flash_addr;
    armed = 1;
  end
  // The command decoder runs as each write completes while the device is not busy.
  always @(posedge wr_n) begin
    if (armed && !busy) begin
      lat_data = data_in;
      cmd_addr = lat_addr[14:0];
      case (step)
        0: if (lat_data == 8'hf0) id_mode = 0;
           else if (cmd_addr == 15'h5555 && lat_data == 8'haa) step = 1;
           else fail();
        1: if (cmd_addr == 15'h2aaa && lat_data == 8'h55) step = 2; else fail();
        2: if (cmd_addr != 15'h5555) fail();
           else if (lat_data == 8'ha0) step = 3;
           else if (lat_data == 8'h80) step = 4;
           else if (lat_data == 8'h90) begin id_mode = 1; step = 0; end
           else if (lat_data == 8'hf0) begin id_mode = 0; step = 0; end
           else fail();
        3: launch(1);
        4: if (cmd_addr == 15'h5555 && lat_data == 8'haa) step = 5; else fail();
        5: if (cmd_addr == 15'h2aaa && lat_data == 8'h55) step = 6; else fail();
        default: if (lat_data == 8'h30) launch(2);
                 else if (lat_data == 8'h10 && cmd_addr == 15'h5555) launch(3);
                 else fail();
      endcase
    end
    armed = 0;
  end
  always @(start_ev) begin
    #(BUSY_NS);
    if (op_kind == 1) mem[op_addr] = op_val;
    else if (op_kind == 3) foreach (mem[i]) mem[i] = 8'hff;
    else for (int i = 0; i < 4096; i++) mem[{op_addr[18:12], i[11:0]}] = 8'hff;
    busy = 0;
  end
  always @(negedge rd_n) begin
    if (busy) begin
      toggle = ~toggle;
      rd_val = {(op_kind == 1) ? ~op_val[7] : 1'b0, toggle, op_val[5:0]};
    end else if (id_mode && flash_addr[18:1] == 18'h0) begin
      rd_val = flash_addr[0] ? DEVICE_CODE : MAKER_CODE;
    end else begin
      rd_val = mem[flash_addr];
    end
    #(ACCESS_NS);
    if (!rd_n) begin
      dq_out = rd_val;
      dq_en = 1;
    end
  end
  always @(posedge rd_n) begin
    dq_en = 0;
    dq_out = ~dq_out;
  end
endmodule
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
// Drives the host controller against the flash model and checks what comes back.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary identity value.
  localparam logic [7:0] DEVICE = 8'h5d; // Arbitrary identity value.
  logic ref_clk, rst, req_valid, req_ready, resp_valid, resp_timeout, dq_en;
  logic data_bus_oe_n, chip_select_n, output_gate_n, write_strobe_n;
  logic [2:0] req_op;
  logic [18:0] req_addr, flash_addr;
  logic [7:0] req_data, resp_data, data_bus_out, dq_out, abort_count;
  int err_total, total_checks;
  // The shared bus: the host when it drives, else whatever the device shows.
  wire logic [7:0] data_bus = data_bus_oe_n ? dq_out : data_bus_out;
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  pfcd_host #(.POLL_LIMIT(64)) u_pfcd_host (.ref_clk(ref_clk), .rst(rst),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_timeout(resp_timeout), .data_bus_in(data_bus), .data_bus_out(data_bus_out),
    .data_bus_oe_n(data_bus_oe_n), .flash_addr(flash_addr), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n));
  pfcd_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_pfcd_flash_model (
    .flash_addr(flash_addr), .data_in(data_bus), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .dq_out(dq_out),
    .dq_en(dq_en), .abort_count(abort_count));
  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Issues one request at the falling edge and waits, bounded, for its response.
  task automatic do_op(input logic [2:0] op, input logic [18:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    @(negedge ref_clk);
    req_valid = 1; req_op = op; req_addr = addr; req_data = data;
    while (req_ready !== 1'b1 && n < 100) begin @(negedge ref_clk); n++; end
    @(negedge ref_clk);
    req_valid = 0;
    while (resp_valid !== 1'b1 && n < 20000) begin @(negedge ref_clk); n++; end
    if (n >= 20000) check("response", 8'h00, 8'h01);
  endtask
  // Reads one byte and compares it.
  task automatic rd(input logic [18:0] addr, input logic [7:0] exp);
    do_op(pfcd_pkg::OP_READ, addr, 8'h00);
    check($sformatf("read %h", addr), resp_data, exp);
  endtask
  // Back-to-back programs with upper address bits set, then a status poll.
  task automatic t_program;
    rd(19'h41234, 8'hff);
    do_op(pfcd_pkg::OP_PROGRAM, 19'h41234, 8'h5a);
    check("timeout", {7'h00, resp_timeout}, 8'h00);
    check("program poll", resp_data, 8'h5a);
    do_op(pfcd_pkg::OP_PROGRAM, 19'h41235, 8'ha5);
    rd(19'h41234, 8'h5a);
    do_op(pfcd_pkg::OP_POLL, 19'h41235, 8'h00);
    check("poll", resp_data, 8'ha5);
    $display("test program done");
  endtask
  // Erases one sector and leaves its neighbour alone.
  task automatic t_sector;
    do_op(pfcd_pkg::OP_PROGRAM, 19'h42000, 8'h33);
    do_op(pfcd_pkg::OP_SECTOR_ERASE, 19'h41fff, 8'h00);
    check("erase poll", resp_data, 8'hff);
    rd(19'h41234, 8'hff);
    rd(19'h41235, 8'hff);
    rd(19'h42000, 8'h33);
    $display("test sector erase done");
  endtask
  // Erases everything, then leaves a marker at address zero.
  task automatic t_chip;
    do_op(pfcd_pkg::OP_CHIP_ERASE, 19'h00000, 8'h00);
    rd(19'h42000, 8'hff);
    do_op(pfcd_pkg::OP_PROGRAM, 19'h00000, 8'h12);
    $display("test chip erase done");
  endtask
  // Identification reads and both kinds of exit.
  task automatic t_ident;
    do_op(pfcd_pkg::OP_ID_ENTRY, 19'h00000, 8'h00);
    rd(19'h00000, MAKER);
    rd(19'h00001, DEVICE);
    rd(19'h40000, 8'hff);
    do_op(pfcd_pkg::OP_ID_EXIT, 19'h00000, 8'h00);
    rd(19'h00000, 8'h12);
    do_op(pfcd_pkg::OP_ID_ENTRY, 19'h00000, 8'h00);
    rd(19'h00001, DEVICE);
    do_op(pfcd_pkg::OP_ID_EXIT_LONG, 19'h00000, 8'h00);
    rd(19'h00001, 8'hff);
    $display("test ident done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge ref_clk) begin
    if (data_bus_oe_n === 1'b0 && dq_en === 1'b1) check("contention", 8'h01, 8'h00);
  end
  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial begin
    err_total = 0; total_checks = 0; rst = 1;
    req_valid = 0; req_op = 3'h0; req_addr = 19'h0; req_data = 8'h00;
    repeat (8) @(negedge ref_clk);
    rst = 0;
    t_program;
    t_sector;
    t_chip;
    t_ident;
    check("aborts", abort_count, 8'h00);
    give_verdict;
  end
  // Watchdog: well beyond the expected run of about two thousand cycles.
  initial begin
    #600000;
    err_total++;
    $display("[FAIL] watchdog expected done seen hang");
    give_verdict;
  end
endmodule
`default_nettype wire
